// ---- hdl/regulator_throttle_cfg.svh ----
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: 16-bit word registers addressed by an 8-bit command code
// Notes:   times are in ns; cycle counts are derived in the design
`ifndef REGULATOR_THROTTLE_CFG_SVH
`define REGULATOR_THROTTLE_CFG_SVH

`define CLK_PERIOD_NS        100

// command codes
`define CMD_FWD_SETPOINT     8'h15
`define CMD_CFG_ZERO         8'h39
`define CMD_CFG_ONE          8'h3c
`define CMD_CFG_TWO          8'h3d
`define CMD_IN_THROTTLE      8'h47
`define CMD_OUT_THROTTLE     8'h48
`define CMD_CFG_THREE        8'h4c
`define CMD_CFG_FOUR         8'h4e

// storable bits, clamp ceilings and reset values
`define SETPOINT_MASK        16'h7ff8
`define SETPOINT_MAX         16'h4000
`define SETPOINT_RESET       16'h1060
`define IN_THR_MASK          16'h1f80
`define IN_THR_MAX           16'h1900
`define IN_THR_RESET         16'h0c00
`define OUT_THR_MASK         16'h3f00
`define OUT_THR_MAX          16'h3200
`define OUT_THR_RESET        16'h1000
`define CFG_ZERO_MASK        16'hffe7
`define CFG_ONE_MASK         16'hffbf
`define CFG_FULL_MASK        16'hffff
`define CFG_RESET            16'h0000

// field positions
`define CFG0_FWD_OFS_HI      15
`define CFG0_FWD_OFS_LO      13
`define CFG0_BOOST_OFS_HI    12
`define CFG0_BOOST_OFS_LO    10
`define CFG0_REV_OFS_HI      9
`define CFG0_REV_OFS_LO      7
`define CFG0_HS_SHORT_HI     6
`define CFG0_HS_SHORT_LO     5
`define CFG0_VIN_LOOP_OFF    2
`define CFG0_IN_DISCHARGE    1
`define CFG0_OUT_DISCHARGE   0
`define CFG2_DEB_HI          10
`define CFG2_DEB_LO          9
`define CFG2_DUR_HI          8
`define CFG2_DUR_LO          6

// alert debounce and minimum duration, ns
`define DEB0_NS              7000
`define DEB1_NS              100000
`define DEB2_NS              500000
`define DEB3_NS              1000000
`define DUR0_NS              10000000
`define DUR1_NS              20000000
`define DUR2_NS              15000000
`define DUR3_NS              5000000
`define DUR4_NS              1000000
`define DUR5_NS              500000
`define DUR6_NS              100000
`define DUR7_NS              0

`endif

// ---- hdl/regulator_throttle_pkg.sv ----
// Purpose: shared types of the setpoint and throttle register bank
// Assumes: nothing beyond the cfg header
// Notes:   constants live in regulator_throttle_cfg.svh
package regulator_throttle_pkg;

  typedef enum logic [1:0] {
    ALERT_IDLE,
    ALERT_DEBOUNCE,
    ALERT_HOLD
  } alert_state_t;

  typedef logic [15:0] reg_word_t;

endpackage : regulator_throttle_pkg

// ---- hdl/regulator_setpoint_throttle_regs.sv ----
// Purpose: setpoint, throttle threshold and config word register bank
// Assumes: word transfers arrive already decoded from the management bus
// Notes:   current codes are in the same bit alignment as the thresholds
//
// Contract
// [RULE1] setpoint word written at command 0x15
// [RULE2] setpoint keeps only bits 14:3
// [RULE3] setpoint clamped to 24.576 V
// [RULE4] zero setpoint write leaves value unchanged
// [RULE5] setpoint reads 6.288 V after power-up
// [RULE6] host programs setpoint before enabling output
// [RULE7] input threshold at 0x47, bits 12:7
// [RULE8] input threshold clamped to field 110010
// [RULE9] input threshold resets to 0x0c00, readable
// [RULE10] input overcurrent asserts alert, debounced, held; compared only while reverse_mode_in is low
// [RULE11] output threshold at 0x48, bits 13:8
// [RULE12] output threshold clamped to field 110010
// [RULE13] output threshold resets to 0x1000, readable
// [RULE14] output overcurrent asserts alert, debounced, held; compared only while reverse_mode_in is high
// [RULE15] config words 0-2 at 0x39, 0x3c, 0x3d
// [RULE16] config words 3-4 at 0x4c, 0x4e
// [RULE17] word zero 15:13 forward buck offset
// [RULE18] word zero 12:10 boost offset, half mV
// [RULE19] word zero 9:7 reverse buck offset
// [RULE20] word zero 6:5 FET short threshold
// [RULE21] word zero bit 2 disables input loop
// [RULE22] word zero bits 1:0 discharge enables
// [RULE23] debounce codes 7us, 100us, 500us, 1ms
// [RULE24] duration codes 10ms down to zero; codes 1 and 2 give 20ms and 15ms
// [RULE25] unused bits ignored, read as zero
`include "regulator_throttle_cfg.svh"

module regulator_setpoint_throttle_regs #(
  parameter int CNT_W     = 18,
  // clock period in ns; a slower claimed clock shortens every nonzero alert time
  parameter int CLK_NS    = `CLK_PERIOD_NS,
  parameter int DEB_CYC_0 = (`DEB0_NS + CLK_NS - 1) / CLK_NS,
  parameter int DEB_CYC_1 = (`DEB1_NS + CLK_NS - 1) / CLK_NS,
  parameter int DEB_CYC_2 = (`DEB2_NS + CLK_NS - 1) / CLK_NS,
  parameter int DEB_CYC_3 = (`DEB3_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_0 = (`DUR0_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_1 = (`DUR1_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_2 = (`DUR2_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_3 = (`DUR3_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_4 = (`DUR4_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_5 = (`DUR5_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_6 = (`DUR6_NS + CLK_NS - 1) / CLK_NS,
  parameter int DUR_CYC_7 = (`DUR7_NS + CLK_NS - 1) / CLK_NS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        wr_stb_in,
  input  wire logic        rd_stb_in,
  output logic      [15:0] rd_data_out,
  output logic             rd_valid_out,
  input  wire logic        reverse_mode_in,
  input  wire logic [15:0] input_current_in,
  input  wire logic [15:0] output_current_in,
  output logic             throttle_alert_n_out,
  output logic      [15:0] setpoint_out,
  output logic signed [4:0] fwd_buck_offset_out,
  output logic signed [4:0] boost_offset_out,
  output logic signed [4:0] rev_buck_offset_out,
  output logic      [1:0]  hs_short_sel_out,
  output logic             vin_loop_disable_out,
  output logic             in_discharge_en_out,
  output logic             out_discharge_en_out,
  output logic      [15:0] cfg_one_out,
  output logic      [15:0] cfg_two_out,
  output logic      [15:0] cfg_three_out,
  output logic      [15:0] cfg_four_out
);

  typedef regulator_throttle_pkg::reg_word_t word_t;

  localparam int CNT_LIM = 1 << CNT_W;

  // refuse settings that the alert counter cannot serve
  if (CLK_NS < 1 || CNT_W < 2 || CNT_W > 30 ||
      DEB_CYC_0 < 1 || DEB_CYC_1 < 1 || DEB_CYC_2 < 1 || DEB_CYC_3 < 1 ||
      DEB_CYC_0 >= CNT_LIM || DEB_CYC_1 >= CNT_LIM ||
      DEB_CYC_2 >= CNT_LIM || DEB_CYC_3 >= CNT_LIM ||
      DUR_CYC_0 >= CNT_LIM || DUR_CYC_1 >= CNT_LIM ||
      DUR_CYC_2 >= CNT_LIM || DUR_CYC_3 >= CNT_LIM ||
      DUR_CYC_4 >= CNT_LIM || DUR_CYC_5 >= CNT_LIM ||
      DUR_CYC_6 >= CNT_LIM || DUR_CYC_7 >= CNT_LIM) begin : g_bad_cfg
    $error("timing counts do not fit the alert counter");
  end

  // mask off unused bits, then cap at the field's ceiling
  function automatic word_t mask_clamp(input word_t val, input word_t mask,
                                       input word_t max);
    word_t m;
    m = val & mask;
    mask_clamp = (m > max) ? max : m;
  endfunction : mask_clamp

  // buck offset codes: 0..3 mV, then -4..-1 mV; result in half-mV units
  function automatic logic signed [4:0] buck_offset(input logic [2:0] c);
    buck_offset = c[2] ? 5'(signed'({2'b11, c}) * 2)
                       : 5'(signed'({2'b00, c}) * 2);
  endfunction : buck_offset

  word_t setpoint_q, setpoint_d;
  word_t in_thr_q, in_thr_d;
  word_t out_thr_q, out_thr_d;
  word_t cfg0_q, cfg1_q, cfg2_q, cfg3_q, cfg4_q;
  word_t rd_data_q, rd_mux;
  logic  rd_valid_q;

  wire hit_setpoint = cmd_code_in == `CMD_FWD_SETPOINT;   // [RULE1]
  wire hit_in_thr   = cmd_code_in == `CMD_IN_THROTTLE;    // [RULE7]
  wire hit_out_thr  = cmd_code_in == `CMD_OUT_THROTTLE;   // [RULE11]
  wire hit_cfg0     = cmd_code_in == `CMD_CFG_ZERO;       // [RULE15]
  wire hit_cfg1     = cmd_code_in == `CMD_CFG_ONE;        // [RULE15]
  wire hit_cfg2     = cmd_code_in == `CMD_CFG_TWO;        // [RULE15]
  wire hit_cfg3     = cmd_code_in == `CMD_CFG_THREE;      // [RULE16]
  wire hit_cfg4     = cmd_code_in == `CMD_CFG_FOUR;       // [RULE16]

  wire word_t sp_masked = wr_data_in & word_t'(`SETPOINT_MASK); // [RULE2]
  wire word_t sp_new    = mask_clamp(wr_data_in, `SETPOINT_MASK,
                                     `SETPOINT_MAX);      // [RULE3]
  // a zero command is taken on the bus but never reaches the register
  wire sp_write = wr_stb_in && hit_setpoint && sp_masked != 16'h0000; // [RULE4]

  assign setpoint_d = sp_write ? sp_new : setpoint_q;
  assign in_thr_d   = (wr_stb_in && hit_in_thr)
                    ? mask_clamp(wr_data_in, `IN_THR_MASK, `IN_THR_MAX)
                    : in_thr_q;                           // [RULE8]
  assign out_thr_d  = (wr_stb_in && hit_out_thr)
                    ? mask_clamp(wr_data_in, `OUT_THR_MASK, `OUT_THR_MAX)
                    : out_thr_q;                          // [RULE12]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      setpoint_q <= `SETPOINT_RESET;                      // [RULE5]
      in_thr_q   <= `IN_THR_RESET;                        // [RULE9]
      out_thr_q  <= `OUT_THR_RESET;                       // [RULE13]
    end else begin
      setpoint_q <= setpoint_d;
      in_thr_q   <= in_thr_d;
      out_thr_q  <= out_thr_d;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg0_q <= `CFG_RESET;                               // [RULE21] [RULE22]
      cfg1_q <= `CFG_RESET;
      cfg2_q <= `CFG_RESET;
      cfg3_q <= `CFG_RESET;
      cfg4_q <= `CFG_RESET;
    end else if (wr_stb_in) begin
      if (hit_cfg0) cfg0_q <= wr_data_in & `CFG_ZERO_MASK; // [RULE25]
      if (hit_cfg1) cfg1_q <= wr_data_in & `CFG_ONE_MASK;  // [RULE25]
      if (hit_cfg2) cfg2_q <= wr_data_in & `CFG_FULL_MASK;
      if (hit_cfg3) cfg3_q <= wr_data_in & `CFG_FULL_MASK;
      if (hit_cfg4) cfg4_q <= wr_data_in & `CFG_FULL_MASK;
    end
  end

  // unmapped codes read as zero so the host sees nothing stale
  assign rd_mux = hit_setpoint ? setpoint_q :
                  hit_in_thr   ? in_thr_q   :
                  hit_out_thr  ? out_thr_q  :
                  hit_cfg0     ? cfg0_q     :
                  hit_cfg1     ? cfg1_q     :
                  hit_cfg2     ? cfg2_q     :
                  hit_cfg3     ? cfg3_q     :
                  hit_cfg4     ? cfg4_q     : 16'h0000;   // [RULE9] [RULE13]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_stb_in;
      if (rd_stb_in) rd_data_q <= rd_mux;
    end
  end

  assign rd_data_out  = rd_data_q;
  assign rd_valid_out = rd_valid_q;

  // config word zero decode
  assign fwd_buck_offset_out = buck_offset(
           cfg0_q[`CFG0_FWD_OFS_HI:`CFG0_FWD_OFS_LO]);   // [RULE17]
  assign rev_buck_offset_out = buck_offset(
           cfg0_q[`CFG0_REV_OFS_HI:`CFG0_REV_OFS_LO]);   // [RULE19]
  assign boost_offset_out = signed'({
           cfg0_q[`CFG0_BOOST_OFS_HI], cfg0_q[`CFG0_BOOST_OFS_HI],
           cfg0_q[`CFG0_BOOST_OFS_HI:`CFG0_BOOST_OFS_LO]}); // [RULE18]
  assign hs_short_sel_out =
           cfg0_q[`CFG0_HS_SHORT_HI:`CFG0_HS_SHORT_LO];  // [RULE20]
  assign vin_loop_disable_out = cfg0_q[`CFG0_VIN_LOOP_OFF]; // [RULE21]
  assign in_discharge_en_out  = cfg0_q[`CFG0_IN_DISCHARGE]; // [RULE22]
  assign out_discharge_en_out = cfg0_q[`CFG0_OUT_DISCHARGE]; // [RULE22]
  assign setpoint_out  = setpoint_q;
  assign cfg_one_out   = cfg1_q;
  assign cfg_two_out   = cfg2_q;
  assign cfg_three_out = cfg3_q;
  assign cfg_four_out  = cfg4_q;

  // throttle alert: the threshold of the active direction is compared
  wire in_over  = input_current_in  > in_thr_q;          // [RULE10]
  wire out_over = output_current_in > out_thr_q;         // [RULE14]
  wire over     = reverse_mode_in ? out_over : in_over;

  wire [1:0] deb_sel = cfg2_q[`CFG2_DEB_HI:`CFG2_DEB_LO];
  wire [2:0] dur_sel = cfg2_q[`CFG2_DUR_HI:`CFG2_DUR_LO];
  logic [CNT_W-1:0] deb_lim, dur_lim;

  always_comb begin
    unique case (deb_sel)                                 // [RULE23]
      2'h0: deb_lim = CNT_W'(DEB_CYC_0);
      2'h1: deb_lim = CNT_W'(DEB_CYC_1);
      2'h2: deb_lim = CNT_W'(DEB_CYC_2);
      2'h3: deb_lim = CNT_W'(DEB_CYC_3);
    endcase
    unique case (dur_sel)                                 // [RULE24]
      3'h0: dur_lim = CNT_W'(DUR_CYC_0);
      3'h1: dur_lim = CNT_W'(DUR_CYC_1);
      3'h2: dur_lim = CNT_W'(DUR_CYC_2);
      3'h3: dur_lim = CNT_W'(DUR_CYC_3);
      3'h4: dur_lim = CNT_W'(DUR_CYC_4);
      3'h5: dur_lim = CNT_W'(DUR_CYC_5);
      3'h6: dur_lim = CNT_W'(DUR_CYC_6);
      3'h7: dur_lim = CNT_W'(DUR_CYC_7);
    endcase
  end

  regulator_throttle_pkg::alert_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      regulator_throttle_pkg::ALERT_IDLE: begin
        if (over) begin
          st_d  = regulator_throttle_pkg::ALERT_DEBOUNCE;
          cnt_d = CNT_W'(1);
        end
      end
      regulator_throttle_pkg::ALERT_DEBOUNCE: begin
        // a dip below threshold restarts the debounce from idle
        if (!over) begin
          st_d = regulator_throttle_pkg::ALERT_IDLE;
        end else if (cnt_q >= deb_lim) begin              // [RULE10] [RULE14]
          st_d  = regulator_throttle_pkg::ALERT_HOLD;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      regulator_throttle_pkg::ALERT_HOLD: begin
        // latched until the minimum time passed and the load is back
        if (cnt_q >= dur_lim && !over) begin              // [RULE10] [RULE14]
          st_d = regulator_throttle_pkg::ALERT_IDLE;
        end else if (cnt_q < dur_lim) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      default: st_d = regulator_throttle_pkg::ALERT_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q  <= regulator_throttle_pkg::ALERT_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign throttle_alert_n_out = st_q != regulator_throttle_pkg::ALERT_HOLD;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  setpoint_zero_kept_a: assert property ( // [RULE4]
    wr_stb_in && hit_setpoint && (wr_data_in & 16'h7ff8) == 16'h0000
    |=> $stable(setpoint_q))
    else $error("zero setpoint write changed the register");

  setpoint_clamp_a: assert property ( // [RULE3]
    setpoint_q <= 16'h4000 && (setpoint_q & 16'h8007) == 16'h0000)
    else $error("setpoint above ceiling or unused bits set");

  setpoint_write_a: assert property ( // [RULE2]
    wr_stb_in && hit_setpoint && (wr_data_in & 16'h7ff8) != 16'h0000
    && (wr_data_in & 16'h7ff8) <= 16'h4000
    |=> setpoint_q == ($past(wr_data_in) & 16'h7ff8))
    else $error("setpoint did not take the masked value");

  in_thr_clamp_a: assert property ( // [RULE8]
    in_thr_q <= 16'h1900 && (in_thr_q & 16'he07f) == 16'h0000)
    else $error("input threshold out of range");

  out_thr_clamp_a: assert property ( // [RULE12]
    out_thr_q <= 16'h3200 && (out_thr_q & 16'hc0ff) == 16'h0000)
    else $error("output threshold out of range");

  read_back_a: assert property ( // [RULE9]
    rd_stb_in && hit_in_thr && !wr_stb_in |=> rd_valid_out
    && rd_data_out == in_thr_q)
    else $error("input threshold read back wrong");

  alert_debounce_a: assert property ( // [RULE10]
    $fell(throttle_alert_n_out) |-> $past(over) && cnt_q == '0)
    else $error("alert asserted without debounced overcurrent");

  alert_hold_a: assert property ( // [RULE14]
    !throttle_alert_n_out && cnt_q < dur_lim |=> !throttle_alert_n_out)
    else $error("alert released before minimum duration");

  cfg0_unused_a: assert property ( // [RULE25]
    cfg0_q[4:3] == 2'b00 && cfg1_q[6] == 1'b0)
    else $error("unused config bits stored");

  out_read_back_a: assert property ( // [RULE13]
    rd_stb_in && hit_out_thr && !wr_stb_in |=> rd_valid_out
    && rd_data_out == out_thr_q)
    else $error("output threshold read back wrong");

  unmapped_read_a: assert property ( // [RULE25]
    rd_stb_in && !(hit_setpoint || hit_in_thr || hit_out_thr || hit_cfg0
    || hit_cfg1 || hit_cfg2 || hit_cfg3 || hit_cfg4)
    |=> rd_valid_out && rd_data_out == 16'h0000)
    else $error("unmapped code did not read as zero");

  in_thr_write_a: assert property ( // [RULE7]
    wr_stb_in && hit_in_thr && (wr_data_in & 16'h1f80) <= 16'h1900
    |=> in_thr_q == ($past(wr_data_in) & 16'h1f80))
    else $error("input threshold did not take the masked value");

  out_thr_write_a: assert property ( // [RULE11]
    wr_stb_in && hit_out_thr && (wr_data_in & 16'h3f00) <= 16'h3200
    |=> out_thr_q == ($past(wr_data_in) & 16'h3f00))
    else $error("output threshold did not take the masked value");

  cfg0_write_a: assert property ( // [RULE22]
    wr_stb_in && hit_cfg0
    |=> {vin_loop_disable_out, in_discharge_en_out, out_discharge_en_out}
        == $past(wr_data_in[2:0]))
    else $error("config word zero enables not taken");

  debounce_restart_a: assert property ( // [RULE10]
    st_q == regulator_throttle_pkg::ALERT_DEBOUNCE && !over
    |=> st_q == regulator_throttle_pkg::ALERT_IDLE)
    else $error("debounce not restarted after a dip");

  debounce_length_a: assert property ( // [RULE23]
    st_q == regulator_throttle_pkg::ALERT_DEBOUNCE && cnt_q < deb_lim
    |=> throttle_alert_n_out)
    else $error("alert asserted before the debounce time");

  alert_latched_a: assert property ( // [RULE10]
    !throttle_alert_n_out && (reverse_mode_in
      ? output_current_in > out_thr_q : input_current_in > in_thr_q)
    |=> !throttle_alert_n_out)
    else $error("alert released while overcurrent persists");

  reverse_select_a: assert property ( // [RULE14]
    st_q == regulator_throttle_pkg::ALERT_IDLE && reverse_mode_in
    && output_current_in <= out_thr_q
    |=> st_q == regulator_throttle_pkg::ALERT_IDLE)
    else $error("reverse alert started below output threshold");

endmodule : regulator_setpoint_throttle_regs

// ---- sim/mgmt_host_model.sv ----
// Purpose: management-bus host that issues decoded word transfers
// Assumes: the bank takes a strobe at the rising edge of clk_in
// Notes:   released lines show the inverse of their last value, so a
//          design that samples them outside a strobe sees garbage
module mgmt_host_model (
  input  wire logic        clk_in,
  output logic      [7:0]  cmd_code_out,
  output logic      [15:0] wr_data_out,
  output logic             wr_stb_out,
  output logic             rd_stb_out,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_code_out = 8'h00;
    wr_data_out  = 16'h0000;
    wr_stb_out   = 1'b0;
    rd_stb_out   = 1'b0;
  end

  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk_in);
    cmd_code_out <= cmd;
    wr_data_out  <= data;
    wr_stb_out   <= 1'b1;
    @(posedge clk_in);
    wr_stb_out   <= 1'b0;
    cmd_code_out <= ~cmd;
    wr_data_out  <= ~data;
    // step past the edge so the caller sees the updated register
    #1;
  endtask : write_word

  task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
                           output logic ok);
    int n;
    @(posedge clk_in);
    cmd_code_out <= cmd;
    rd_stb_out   <= 1'b1;
    @(posedge clk_in);
    rd_stb_out   <= 1'b0;
    cmd_code_out <= ~cmd;
    ok   = 1'b0;
    data = 16'h0000;
    n    = 0;
    #1;
    while (!ok && n < 4) begin
      if (rd_valid_in === 1'b1) begin
        ok   = 1'b1;
        data = rd_data_in;
      end else begin
        @(posedge clk_in);
        #1;
        n++;
      end
    end
  endtask : read_word
endmodule : mgmt_host_model

// ---- sim/regulator_setpoint_throttle_regs_tb.sv ----
// Purpose: self-checking bench for the setpoint and throttle bank
// Assumes: shortened debounce and duration counts, see instance
// Notes:   hold time is checked within one cycle of the count
`include "regulator_throttle_cfg.svh"
module regulator_setpoint_throttle_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                clk_in = 1'b0;
  logic                rst_in = 1'b1;
  logic [7:0]          cmd_code;
  logic [15:0]         wr_data, rd_data, setpoint;
  logic                wr_stb, rd_stb, rd_valid, alert_n;
  logic                reverse_mode = 1'b0;
  logic [15:0]         in_cur = 16'h0000;
  logic [15:0]         out_cur = 16'h0000;
  logic signed [4:0]   fwd_ofs, boost_ofs, rev_ofs;
  logic [1:0]          hs_sel;
  logic                vin_off, in_dis, out_dis;
  logic [15:0]         cfg1_o, cfg2_o, cfg3_o, cfg4_o;
  int                  n_mismatch = 0;
  int                  total_checks = 0;
  logic [7:0]          cmd_tab [9] = '{8'h15, 8'h39, 8'h3c, 8'h3d, 8'h47,
                                       8'h48, 8'h4c, 8'h4e, 8'h00};
  logic [15:0]         rst_tab [9] = '{16'h1060, 16'h0, 16'h0, 16'h0,
                                       16'h0c00, 16'h1000, 16'h0, 16'h0, 16'h0};
  logic [15:0]         max_tab [9] = '{16'h4000, 16'hffe7, 16'hffbf, 16'hffff,
                                       16'h1900, 16'h3200, 16'hffff, 16'hffff,
                                       16'h0};
  // alert times counted in 5 us cycles, rounded up
  int                  deb_tab [4] = '{2, 20, 100, 200};
  int                  dur_tab [8] = '{2000, 4000, 3000, 1000, 200, 100, 20,
                                       0};

  always #50 clk_in = ~clk_in;

  // a claimed 5 us cycle keeps the longest hold at a few thousand clocks
  regulator_setpoint_throttle_regs #(
    .CLK_NS(5000)
  ) u_regulator_setpoint_throttle_regs (
    .clk_in(clk_in), .rst_in(rst_in), .cmd_code_in(cmd_code),
    .wr_data_in(wr_data), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .reverse_mode_in(reverse_mode), .input_current_in(in_cur),
    .output_current_in(out_cur), .throttle_alert_n_out(alert_n),
    .setpoint_out(setpoint), .fwd_buck_offset_out(fwd_ofs),
    .boost_offset_out(boost_ofs), .rev_buck_offset_out(rev_ofs),
    .hs_short_sel_out(hs_sel), .vin_loop_disable_out(vin_off),
    .in_discharge_en_out(in_dis), .out_discharge_en_out(out_dis),
    .cfg_one_out(cfg1_o), .cfg_two_out(cfg2_o), .cfg_three_out(cfg3_o),
    .cfg_four_out(cfg4_o)
  );

  mgmt_host_model u_mgmt_host_model (
    .clk_in(clk_in), .cmd_code_out(cmd_code), .wr_data_out(wr_data),
    .wr_stb_out(wr_stb), .rd_stb_out(rd_stb), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid)
  );

  task automatic check_word(input regulator_throttle_pkg::reg_word_t got,
                            input regulator_throttle_pkg::reg_word_t exp,
                            input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_count(input int got, input int lo, input int hi,
                             input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : check_count

  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_mgmt_host_model.read_word(cmd, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("BAD t=%0t no read answer", $time);
    end
    check_word(d, exp, "read");
  endtask : rd_chk

  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    u_mgmt_host_model.write_word(cmd, data);
  endtask : wr

  task automatic alert_run(input int d, input int m);
    int n;
    n = 0;
    while (alert_n !== 1'b0 && n < 5000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check_count(n, d + 1, d + 1, "debounce");
    @(posedge clk_in);
    in_cur  <= 16'h0000;
    out_cur <= 16'h0000;
    n = 0;
    #1;
    while (alert_n === 1'b0 && n < 5000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check_count(n, m - 1, m + 1, "hold");
  endtask : alert_run

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    #3000000;
    n_mismatch++;
    $display("BAD t=%0t run hung", $time);
    final_report();
  end

  initial begin
    logic [15:0] w;
    logic        seen_low;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values first, then saturating writes, unmapped code last
    for (int i = 0; i < 9; i++) begin
      rd_chk(cmd_tab[i], rst_tab[i]);
    end
    for (int i = 0; i < 9; i++) begin
      wr(cmd_tab[i], 16'hffff);
      rd_chk(cmd_tab[i], max_tab[i]);
    end
    check_word(cfg1_o, 16'hffbf, "cfg1 port");
    check_word(cfg2_o, 16'hffff, "cfg2 port");
    check_word(cfg3_o, 16'hffff, "cfg3 port");
    check_word(cfg4_o, 16'hffff, "cfg4 port");
    $display("test reset_and_clamp done");
    wr(`CMD_FWD_SETPOINT, 16'h8007);
    rd_chk(`CMD_FWD_SETPOINT, 16'h4000);
    wr(`CMD_FWD_SETPOINT, 16'h0000);
    rd_chk(`CMD_FWD_SETPOINT, 16'h4000);
    wr(`CMD_FWD_SETPOINT, 16'h9234);
    rd_chk(`CMD_FWD_SETPOINT, 16'h1230);
    check_word(setpoint, 16'h1230, "setpoint port");
    wr(`CMD_IN_THROTTLE, 16'he0ff);
    rd_chk(`CMD_IN_THROTTLE, 16'h0080);
    wr(`CMD_OUT_THROTTLE, 16'hc1ff);
    rd_chk(`CMD_OUT_THROTTLE, 16'h0100);
    $display("test masking done");
    for (int c = 0; c < 8; c++) begin
      w = 16'((c << 13) | (c << 10) | (c << 7) | ((c & 3) << 5) | c);
      wr(`CMD_CFG_ZERO, w);
      check_word({{11{fwd_ofs[4]}}, fwd_ofs},
                 16'(c < 4 ? 2 * c : 2 * c - 16), "fwd");
      check_word({{11{boost_ofs[4]}}, boost_ofs},
                 16'(c < 4 ? c : c - 8), "boost");
      check_word({{11{rev_ofs[4]}}, rev_ofs},
                 16'(c < 4 ? 2 * c : 2 * c - 16), "rev");
      check_word({14'h0, hs_sel}, 16'(c & 3), "fet");
      check_word({13'h0, vin_off, in_dis, out_dis}, 16'(c), "en");
    end
    $display("test config_zero done");
    wr(`CMD_IN_THROTTLE, 16'h0c80);
    wr(`CMD_OUT_THROTTLE, 16'h1200);
    wr(`CMD_CFG_TWO, 16'h0000);
    // a two-cycle excursion must die in the debounce window
    @(posedge clk_in);
    in_cur <= 16'h0d00;
    repeat (2) @(posedge clk_in);
    in_cur <= 16'h0000;
    seen_low = 1'b0;
    repeat (8) begin
      @(posedge clk_in);
      #1;
      if (alert_n !== 1'b1) seen_low = 1'b1;
    end
    check_word({15'h0, seen_low}, 16'h0000, "glitch");
    for (int i = 0; i < 8; i++) begin
      wr(`CMD_CFG_TWO, 16'(((i % 4) << 9) | (i << 6)));
      @(posedge clk_in);
      in_cur <= 16'h0d00;
      alert_run(deb_tab[i % 4], dur_tab[i]);
    end
    $display("test input_alert done");
    wr(`CMD_CFG_TWO, 16'h02c0);
    @(posedge clk_in);
    reverse_mode <= 1'b1;
    out_cur      <= 16'h1300;
    alert_run(deb_tab[1], dur_tab[3]);
    $display("test output_alert done");
    final_report();
  end
endmodule : regulator_setpoint_throttle_regs_tb
